// ===== logic/acr_regs.sv
/*
  acr_regs: control, result and compare registers of a successive
  approximation converter, with start/abort sequencing, result interlock
  and automatic compare.
  assumes: one clock, synchronous bus strobes, the analog core reports a
  finished conversion as a one-cycle pulse with its raw 12-bit result.
*/
// Behaviour
// - active flag set on start, cleared end/abort
// - trigger select: software write or hardware input
// - compare enable bit gates compare
// - direction: less-than or greater-or-equal
// - 12-bit: high byte holds upper four bits
// - 10-bit: upper two bits, 11:10 zero
// - 8-bit: high byte reads zero
// - results update unless compare enabled and false
// - high read locks results until low read
// - results of completions during lock are discarded
// - 8-bit mode: high read never locks
// - low byte holds low eight bits
// - 12-bit compare uses four high compare bits
// - 10-bit compare uses compare bits 9:8
// - 8-bit compare ignores high compare register
// - low compare bits always compared
// - complete flag set only when compare true or compare disabled
// - control-one write aborts, restarts in software trigger unless disabled
// - mode field selects 8, 12, 10 bits
`timescale 1ns/10ps
`default_nettype none
module acr_regs (
  input wire logic clk_i, // bus clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic ce_i, // clock enable, freezes all state when low
  input wire acr_pkg::acr_bus_req_t bus_i, // register request
  output logic [7:0] rdata_o, // read data, cycle after read strobe
  input wire logic hw_trigger_i, // hardware_trigger_input
  input wire acr_pkg::acr_conv_t conv_i, // core completion and raw result
  output logic conv_start_o, // start pulse to the analog core
  output logic conv_abort_o, // abort pulse to the analog core
  output logic [4:0] channel_o, // channel_select
  output logic [1:0] mode_o, // conversion mode
  output logic complete_o // conversion_complete_flag
);
  import acr_pkg::*;

  typedef enum logic [0:0] {ACR_IDLE, ACR_BUSY} acr_state_t;

  acr_state_t state_r;
  logic [7:0] ctrl_one_r;
  logic [7:0] ctrl_two_r;
  logic [7:0] cv_high_r;
  logic [7:0] cv_low_r;
  logic [1:0] mode_r;
  logic [11:0] result_r;
  logic lock_r;
  logic complete_r;
  logic hw_prev_r;
  logic [7:0] rdata_r;

  acr_state_t state_nxt;
  logic [7:0] ctrl_one_nxt;
  logic [7:0] ctrl_two_nxt;
  logic [7:0] cv_high_nxt;
  logic [7:0] cv_low_nxt;
  logic [1:0] mode_nxt;
  logic [11:0] result_nxt;
  logic lock_nxt;
  logic complete_nxt;
  logic hw_prev_nxt;
  logic [7:0] rdata_nxt;

  // mask a raw or stored value to the width of the active mode
  function automatic logic [11:0] acr_width(input logic [1:0] m,
                                            input logic [11:0] v);
    case (m)
      ACR_MODE_12: acr_width = v;
      ACR_MODE_10: acr_width = {2'h0, v[9:0]};
      default: acr_width = {4'h0, v[7:0]};
    endcase
  endfunction

  // one strobe aimed at one register index
  function automatic logic acr_hit(input logic strobe, input logic [2:0] a,
                                   input logic [2:0] idx);
    acr_hit = strobe && a == idx;
  endfunction

  // register read mux; unmapped indices read zero
  function automatic logic [7:0] acr_read(input logic [2:0] a,
                                          input logic cc,
                                          input logic busy,
                                          input logic [7:0] one,
                                          input logic [7:0] two,
                                          input logic [11:0] res,
                                          input logic [7:0] cvh,
                                          input logic [7:0] cvl,
                                          input logic [1:0] m);
    case (a)
      ACR_ADDR_CTRL_ONE: acr_read = {cc, one[6:0]};
      ACR_ADDR_CTRL_TWO: acr_read = {busy, two[6:0]};
      ACR_ADDR_RES_HIGH: acr_read = {4'h0, res[11:8]};
      ACR_ADDR_RES_LOW: acr_read = res[7:0];
      ACR_ADDR_CV_HIGH: acr_read = cvh;
      ACR_ADDR_CV_LOW: acr_read = cvl;
      ACR_ADDR_CONFIG: acr_read = {4'h0, m, 2'h0};
      default: acr_read = 8'h00;
    endcase
  endfunction

  logic wr_one;
  logic rd_high;
  logic rd_low;
  logic hw_edge;
  logic start;
  logic abort;
  logic [11:0] res_m;
  logic [11:0] cv_m;
  logic cmp_true;
  logic store_ok;
  logic done;
  logic wr_two;
  logic wr_cvh;
  logic wr_cvl;
  logic wr_cfg;

  // bus decode; state only moves while the clock enable is high
  assign wr_one = acr_hit(bus_i.wr, bus_i.addr, ACR_ADDR_CTRL_ONE);
  assign wr_two = acr_hit(bus_i.wr, bus_i.addr, ACR_ADDR_CTRL_TWO);
  assign wr_cvh = acr_hit(bus_i.wr, bus_i.addr, ACR_ADDR_CV_HIGH);
  assign wr_cvl = acr_hit(bus_i.wr, bus_i.addr, ACR_ADDR_CV_LOW);
  assign wr_cfg = acr_hit(bus_i.wr, bus_i.addr, ACR_ADDR_CONFIG);
  assign rd_high = acr_hit(bus_i.rd, bus_i.addr, ACR_ADDR_RES_HIGH);
  assign rd_low = acr_hit(bus_i.rd, bus_i.addr, ACR_ADDR_RES_LOW);
  // a completion in the cycle of a control-one write is dropped
  assign hw_edge = hw_trigger_i && !hw_prev_r;
  assign done = conv_i.done && state_r == ACR_BUSY && !wr_one;

  // start source by trigger select disabled channel blocks it
  always_comb begin
    start = 1'b0;
    if (!ctrl_two_r[ACR_BIT_TRIG_SEL]) begin
      start = wr_one && bus_i.wdata[ACR_CH_MSB:ACR_CH_LSB] != ACR_CH_OFF;
    end else if (ctrl_one_r[ACR_CH_MSB:ACR_CH_LSB] != ACR_CH_OFF) begin
      start = hw_edge && state_r == ACR_IDLE;
    end
  end
  assign abort = wr_one && state_r == ACR_BUSY;

  // compare in the active width
  assign res_m = acr_width(mode_r, conv_i.data);
  // high compare byte: four bits two none
  assign cv_m = acr_width(mode_r, {cv_high_r[3:0], cv_low_r});
  always_comb begin
    if (ctrl_two_r[ACR_BIT_CMP_GE]) begin
      cmp_true = res_m >= cv_m;
    end else begin
      cmp_true = res_m < cv_m;
    end
  end
  // compare only gates when enabled
  assign store_ok = !ctrl_two_r[ACR_BIT_CMP_EN] || cmp_true;

  // next state: idle until a start, busy until completion or abort
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ACR_IDLE: begin
        if (start) begin
          state_nxt = ACR_BUSY;
        end
      end
      ACR_BUSY: begin
        // an abort that restarts at once keeps the sequencer busy
        if ((abort && !start) || done) begin
          state_nxt = ACR_IDLE;
        end
      end
      default: state_nxt = ACR_IDLE;
    endcase
  end

  // the busy state is what the active flag reports
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ACR_IDLE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // control one holds the channel; in software trigger the write itself restarts
  always_comb begin
    ctrl_one_nxt = ctrl_one_r;
    if (wr_one) begin
      ctrl_one_nxt = bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_one_r <= ACR_CTRL_ONE_RST;
    end else if (ce_i) begin
      ctrl_one_r <= ctrl_one_nxt;
    end
  end

  // control two: writable bits 6:4; reserved 3:0 kept zero
  always_comb begin
    ctrl_two_nxt = ctrl_two_r;
    if (wr_two) begin
      ctrl_two_nxt = {1'b0, bus_i.wdata[6:4], 4'h0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_two_r <= ACR_CTRL_TWO_RST;
    end else if (ce_i) begin
      ctrl_two_r <= ctrl_two_nxt;
    end
  end

  // compare high keeps only the bits that some mode can compare
  always_comb begin
    cv_high_nxt = cv_high_r;
    if (wr_cvh) begin
      cv_high_nxt = {4'h0, bus_i.wdata[3:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cv_high_r <= ACR_CV_RST;
    end else if (ce_i) begin
      cv_high_r <= cv_high_nxt;
    end
  end

  // compare low byte, used in every mode
  always_comb begin
    cv_low_nxt = cv_low_r;
    if (wr_cvl) begin
      cv_low_nxt = bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cv_low_r <= ACR_CV_RST;
    end else if (ce_i) begin
      cv_low_r <= cv_low_nxt;
    end
  end

  // mode field; stored results are stale after a change
  always_comb begin
    mode_nxt = mode_r;
    if (wr_cfg) begin
      mode_nxt = bus_i.wdata[ACR_MODE_MSB:ACR_MODE_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= ACR_MODE_RST;
    end else if (ce_i) begin
      mode_r <= mode_nxt;
    end
  end

  // previous trigger level for the rising-edge detector
  always_comb begin
    hw_prev_nxt = hw_trigger_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hw_prev_r <= 1'b0;
    end else if (ce_i) begin
      hw_prev_r <= hw_prev_nxt;
    end
  end

  // result store: gated by compare dropped while locked
  always_comb begin
    result_nxt = result_r;
    if (done && store_ok && !lock_r) begin
      result_nxt = res_m;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_r <= ACR_RES_RST;
    end else if (ce_i) begin
      result_r <= result_nxt;
    end
  end

  // interlock: high read locks in every mode except 8-bit
  // the lock blocks storage only, never the complete flag
  always_comb begin
    lock_nxt = lock_r;
    if (rd_low) begin
      lock_nxt = 1'b0;
    end else if (rd_high && mode_r != ACR_MODE_8) begin
      lock_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_r <= 1'b0;
    end else if (ce_i) begin
      lock_r <= lock_nxt;
    end
  end

  // complete flag: set wins over clear
  // so a completion in a result-low read cycle is never lost
  always_comb begin
    complete_nxt = complete_r;
    if (done && store_ok) begin
      complete_nxt = 1'b1;
    end else if (wr_one || rd_low) begin
      complete_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      complete_r <= 1'b0;
    end else if (ce_i) begin
      complete_r <= complete_nxt;
    end
  end

  // read data stands one cycle; the bus idles at zero between reads
  always_comb begin
    rdata_nxt = 8'h00;
    if (bus_i.rd) begin
      rdata_nxt = acr_read(bus_i.addr, complete_r, state_r == ACR_BUSY,
                           ctrl_one_r, ctrl_two_r, result_r, cv_high_r,
                           cv_low_r, mode_r);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else if (ce_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign conv_start_o = ce_i && start;
  assign conv_abort_o = ce_i && abort;
  assign channel_o = ctrl_one_r[ACR_CH_MSB:ACR_CH_LSB];
  assign mode_o = mode_r;
  assign complete_o = complete_r;
endmodule
`default_nettype wire

// ===== logic/acr_pkg.sv
/*
  acr_pkg: register indices, field positions, reset values, mode codes
  and bus carrier types for the converter compare/result slice.
  assumes: compiled before logic/acr_regs.sv.
*/
package acr_pkg;
  localparam logic [2:0] ACR_ADDR_CTRL_ONE = 3'h0;
  localparam logic [2:0] ACR_ADDR_CTRL_TWO = 3'h1;
  localparam logic [2:0] ACR_ADDR_RES_HIGH = 3'h2;
  localparam logic [2:0] ACR_ADDR_RES_LOW = 3'h3;
  localparam logic [2:0] ACR_ADDR_CV_HIGH = 3'h4;
  localparam logic [2:0] ACR_ADDR_CV_LOW = 3'h5;
  localparam logic [2:0] ACR_ADDR_CONFIG = 3'h6;

  localparam int ACR_BIT_ACTIVE = 7;
  localparam int ACR_BIT_TRIG_SEL = 6;
  localparam int ACR_BIT_CMP_EN = 5;
  localparam int ACR_BIT_CMP_GE = 4;
  localparam int ACR_BIT_COMPLETE = 7;
  localparam int ACR_CH_LSB = 0;
  localparam int ACR_CH_MSB = 4;
  localparam int ACR_MODE_LSB = 2;
  localparam int ACR_MODE_MSB = 3;

  localparam logic [4:0] ACR_CH_OFF = 5'h1f;
  localparam logic [7:0] ACR_CTRL_ONE_RST = 8'h1f;
  localparam logic [7:0] ACR_CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] ACR_CV_RST = 8'h00;
  localparam logic [11:0] ACR_RES_RST = 12'h000;
  localparam logic [1:0] ACR_MODE_RST = 2'h0;
  localparam logic [7:0] ACR_CONV_CYCLES = 8'h14;

  localparam logic [1:0] ACR_MODE_8 = 2'h0;
  localparam logic [1:0] ACR_MODE_12 = 2'h1;
  localparam logic [1:0] ACR_MODE_10 = 2'h2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } acr_bus_req_t;

  typedef struct packed {
    logic done;
    logic [11:0] data;
  } acr_conv_t;
endpackage

// ===== test/acr_regs_assertions.sv
/*
  acr_assertions: port-level checks of the compare/result register slice.
  assumes: bound to acr_regs, single clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module acr_assertions (
  input wire logic clk_i, // bus clock
  input wire logic rst_i, // synchronous reset
  input wire logic ce_i, // clock enable
  input wire acr_pkg::acr_bus_req_t bus_i, // register request
  input wire logic [7:0] rdata_o, // read data
  input wire logic hw_trigger_i, // hardware trigger
  input wire acr_pkg::acr_conv_t conv_i, // core completion
  input wire logic conv_start_o, // start pulse
  input wire logic conv_abort_o, // abort pulse
  input wire logic [4:0] channel_o, // channel field
  input wire logic [1:0] mode_o, // conversion mode
  input wire logic complete_o // complete flag
);
  import acr_pkg::*;
  logic trig_r, cmpen_r, act_r, lock_r, w1, rl;
  assign w1 = ce_i && bus_i.wr && bus_i.addr == ACR_ADDR_CTRL_ONE;
  assign rl = ce_i && bus_i.rd && bus_i.addr == ACR_ADDR_RES_LOW;
  // shadow of control-two bits and of the busy/lock state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {trig_r, cmpen_r, act_r, lock_r} <= 4'h0;
    end else if (ce_i) begin
      if (bus_i.wr && bus_i.addr == ACR_ADDR_CTRL_TWO) begin
        {trig_r, cmpen_r} <= bus_i.wdata[6:5];
      end
      act_r <= conv_start_o | (act_r & ~conv_i.done & ~conv_abort_o);
      if (rl) begin
        lock_r <= 1'b0;
      end else if (bus_i.rd && bus_i.addr == ACR_ADDR_RES_HIGH) begin
        lock_r <= mode_o != ACR_MODE_8;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  start_sw_a: assert property (w1 && bus_i.wdata[4:0] != ACR_CH_OFF &&
    !trig_r |-> conv_start_o) else $error("no start on control write");
  off_ch_a: assert property (w1 && bus_i.wdata[4:0] == ACR_CH_OFF
    |-> !conv_start_o) else $error("start with channel off");
  abort_wr_a: assert property (w1 && act_r |-> conv_abort_o)
    else $error("busy write did not abort");
  hw_start_a: assert property (ce_i && trig_r &&
    $rose(hw_trigger_i) && !act_r && channel_o != ACR_CH_OFF && !w1
    |-> conv_start_o) else $error("hardware trigger ignored");
  sw_no_hw_a: assert property (ce_i && !trig_r && !w1 &&
    $rose(hw_trigger_i) |-> !conv_start_o) else $error("stray start");
  ch_wr_a: assert property (w1
    |=> channel_o == $past(bus_i.wdata[4:0]))
    else $error("channel not written");
  mode_wr_a: assert property (ce_i && bus_i.wr &&
    bus_i.addr == ACR_ADDR_CONFIG |=> mode_o == $past(bus_i.wdata[3:2]))
    else $error("mode not written");
  flag_set_a: assert property (act_r && conv_i.done && ce_i &&
    !cmpen_r && !w1 && !lock_r |=> complete_o) else $error("complete not set");
  flag_clr_a: assert property ((rl || w1) && !conv_i.done
    |=> !complete_o) else $error("complete not cleared");
  cover property (conv_start_o && trig_r);
  cover property (conv_abort_o);
  cover property ($rose(complete_o) && cmpen_r);
endmodule
bind acr_regs acr_assertions chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .hw_trigger_i(hw_trigger_i),
  .conv_i(conv_i), .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
  .channel_o(channel_o), .mode_o(mode_o), .complete_o(complete_o));
`default_nettype wire

// ===== test/acr_regs_test.sv
/*
  acr_regs_test: drives register bus and core completions, checks reads.
  assumes: acr_pkg and acr_regs compiled first; clock enable high except for one frozen write.
*/
`timescale 1ns/10ps
`default_nettype none
module acr_regs_test;
  import acr_pkg::*;
  logic clk_i, rst_i, hw_trigger_i, conv_start_o, conv_abort_o, complete_o;
  acr_bus_req_t bus_i;
  acr_conv_t conv_i;
  logic [7:0] rdata_o, e;
  logic [4:0] channel_o;
  logic [1:0] mode_o;
  logic rd_d;
  logic ce_i;
  logic [11:0] r;
  logic [7:0] exp_q[$];
  int num_errors, comparisons;
  acr_regs dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .hw_trigger_i(hw_trigger_i), .conv_i(conv_i),
    .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
    .channel_o(channel_o), .mode_o(mode_o), .complete_o(complete_o));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // read notes expected data; write pushes nothing
  task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{wr: w, rd: !w, addr: a, wdata: w ? d : 8'h00};
    if (!w) exp_q.push_back(d);
    @(posedge clk_i);
    bus_i <= '0;
  endtask
  task automatic fin(input logic [11:0] v);
    @(posedge clk_i);
    conv_i <= '{done: 1'b1, data: v};
    @(posedge clk_i);
    conv_i <= '{done: 1'b0, data: ~v};
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) rd_d <= bus_i.rd;
  always @(negedge clk_i) begin
    if (rd_d === 1'b1) begin
      e = exp_q.pop_front();
      comparisons++;
      if (rdata_o !== e) begin
        num_errors++;
        $display("Error %0t got %h exp %h", $time, rdata_o, e);
      end
    end
  end
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  initial begin
    bus_i = '0;
    conv_i = '0;
    hw_trigger_i = 1'b0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    num_errors = 0;
    comparisons = 0;
    void'($urandom(32'hdb61));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    op(0, ACR_ADDR_CTRL_TWO, 8'h00);
    op(0, 3'h7, 8'h00);
    op(1, ACR_ADDR_CONFIG, {4'h0, ACR_MODE_12, 2'h0});
    op(1, ACR_ADDR_CTRL_ONE, 8'h03);
    op(0, ACR_ADDR_CTRL_TWO, 8'h80);
    r = 12'($urandom);
    fin(r);
    op(0, ACR_ADDR_CTRL_TWO, 8'h00);
    op(0, ACR_ADDR_RES_HIGH, {4'h0, r[11:8]});
    op(1, ACR_ADDR_CTRL_ONE, 8'h03);
    fin(~r);
    op(0, ACR_ADDR_RES_LOW, r[7:0]);
    op(0, ACR_ADDR_RES_HIGH, {4'h0, r[11:8]});
    op(0, ACR_ADDR_RES_LOW, r[7:0]);
    op(1, ACR_ADDR_CONFIG, {4'h0, ACR_MODE_10, 2'h0});
    op(1, ACR_ADDR_CTRL_ONE, 8'h03);
    fin(r);
    op(0, ACR_ADDR_RES_HIGH, {6'h0, r[9:8]});
    op(0, ACR_ADDR_RES_LOW, r[7:0]);
    op(1, ACR_ADDR_CV_HIGH, 8'h06);
    op(1, ACR_ADDR_CV_LOW, 8'h00);
    op(1, ACR_ADDR_CTRL_TWO, 8'h30);
    op(1, ACR_ADDR_CTRL_ONE, 8'h03);
    fin(12'h1ff);
    op(0, ACR_ADDR_RES_HIGH, {6'h0, r[9:8]});
    op(0, ACR_ADDR_RES_LOW, r[7:0]);
    op(1, ACR_ADDR_CTRL_ONE, 8'h03);
    fin(12'h200);
    op(0, ACR_ADDR_RES_HIGH, 8'h02);
    op(0, ACR_ADDR_RES_LOW, 8'h00);
    op(1, ACR_ADDR_CTRL_TWO, 8'h20);
    op(1, ACR_ADDR_CTRL_ONE, 8'h03);
    fin(12'h1ff);
    op(0, ACR_ADDR_RES_HIGH, 8'h01);
    op(0, ACR_ADDR_RES_LOW, 8'hff);
    op(1, ACR_ADDR_CONFIG, {4'h0, ACR_MODE_8, 2'h0});
    op(1, ACR_ADDR_CV_HIGH, 8'h0f);
    op(1, ACR_ADDR_CV_LOW, 8'h80);
    op(1, ACR_ADDR_CTRL_ONE, 8'h03);
    fin(12'hf7f);
    op(0, ACR_ADDR_RES_HIGH, 8'h00);
    op(1, ACR_ADDR_CTRL_ONE, 8'h03);
    fin(12'h012);
    op(0, ACR_ADDR_RES_LOW, 8'h12);
    op(1, ACR_ADDR_CTRL_ONE, 8'h03);
    op(1, ACR_ADDR_CTRL_ONE, 8'h1f);
    op(0, ACR_ADDR_CTRL_TWO, 8'h20);
    op(1, ACR_ADDR_CTRL_TWO, 8'h40);
    op(1, ACR_ADDR_CTRL_ONE, 8'h03);
    op(0, ACR_ADDR_CTRL_TWO, 8'h40);
    @(posedge clk_i);
    hw_trigger_i <= 1'b1;
    op(0, ACR_ADDR_CTRL_TWO, 8'hc0);
    fin(12'h0a5);
    hw_trigger_i <= 1'b0;
    op(0, ACR_ADDR_RES_LOW, 8'ha5);
    @(posedge clk_i);
    ce_i <= 1'b0;
    op(1, ACR_ADDR_CTRL_TWO, 8'h30);
    ce_i <= 1'b1;
    op(0, ACR_ADDR_CTRL_TWO, 8'h40);
    repeat (3) @(posedge clk_i);
    summarize();
  end
endmodule
`default_nettype wire
